// >>> logic/bsle_defines.vh
// Constants for the skip, branch and load execution block
`ifndef BSLE_DEFINES_VH
`define BSLE_DEFINES_VH

// ----------------------------------------------------------------
// Operation codes presented by the decode stage
// ----------------------------------------------------------------
`define BSLE_OP_W                          5
`define BSLE_OP_SKIP_IF_REG_BIT_CLEAR      5'h00
`define BSLE_OP_SKIP_IF_REG_BIT_SET        5'h01
`define BSLE_OP_SKIP_IF_IO_BIT_CLEAR       5'h02
`define BSLE_OP_SKIP_IF_IO_BIT_SET         5'h03
`define BSLE_OP_BRANCH_FLAG_SET            5'h04
`define BSLE_OP_BRANCH_FLAG_CLEAR          5'h05
`define BSLE_OP_BRANCH_ON_EQUAL            5'h06
`define BSLE_OP_BRANCH_ON_UNEQUAL          5'h07
`define BSLE_OP_BRANCH_CARRY_SET           5'h08
`define BSLE_OP_BRANCH_CARRY_CLEAR         5'h09
`define BSLE_OP_BRANCH_UNSIGNED_GE         5'h0a
`define BSLE_OP_BRANCH_UNSIGNED_LT         5'h0b
`define BSLE_OP_BRANCH_NEGATIVE            5'h0c
`define BSLE_OP_BRANCH_NONNEGATIVE         5'h0d
`define BSLE_OP_BRANCH_SIGNED_GE           5'h0e
`define BSLE_OP_BRANCH_SIGNED_LT           5'h0f
`define BSLE_OP_BRANCH_HALFCARRY_SET       5'h10
`define BSLE_OP_BRANCH_HALFCARRY_CLEAR     5'h11
`define BSLE_OP_BRANCH_USER_BIT_SET        5'h12
`define BSLE_OP_BRANCH_USER_BIT_CLEAR      5'h13
`define BSLE_OP_BRANCH_OVERFLOW_SET        5'h14
`define BSLE_OP_BRANCH_OVERFLOW_CLEAR      5'h15
`define BSLE_OP_BRANCH_INTERRUPTS_ON       5'h16
`define BSLE_OP_BRANCH_INTERRUPTS_OFF      5'h17
`define BSLE_OP_POINTER_LOAD_POST_INC      5'h18
`define BSLE_OP_POINTER_LOAD_PRE_DEC       5'h19
`define BSLE_OP_POINTER_OFFSET_LOAD        5'h1a
`define BSLE_OP_DIRECT_MEMORY_LOAD         5'h1b

// ----------------------------------------------------------------
// Status flag bit positions
// ----------------------------------------------------------------
`define BSLE_FLAG_C                        0
`define BSLE_FLAG_Z                        1
`define BSLE_FLAG_N                        2
`define BSLE_FLAG_V                        3
`define BSLE_FLAG_H                        5
`define BSLE_FLAG_T                        6
`define BSLE_FLAG_I                        7

// ----------------------------------------------------------------
// Pointer pair selectors
// ----------------------------------------------------------------
`define BSLE_PTR_X                         2'h0
`define BSLE_PTR_Y                         2'h1
`define BSLE_PTR_Z                         2'h2

// ----------------------------------------------------------------
// Program counter steps and extra wait cycles
// ----------------------------------------------------------------
`define BSLE_PC_STEP_ONE                   16'h0001
`define BSLE_PC_STEP_TWO                   16'h0002
`define BSLE_PC_STEP_THREE                 16'h0003
`define BSLE_WAIT_NONE                     2'h0
`define BSLE_WAIT_ONE                      2'h1
`define BSLE_WAIT_TWO                      2'h2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define BSLE_RST_ADDR                      16'h0000
`define BSLE_RST_BYTE                      8'h00

`endif

// >>> logic/bsle_cond.v
// Condition evaluator for skips and flag-tested branches
`include "bsle_defines.vh"

module bsle_cond (
  input  wire [4:0] op,
  input  wire [7:0] flags,
  input  wire [2:0] sel_bit,
  input  wire [7:0] reg_val,
  input  wire [7:0] io_val,
  output reg        hit
);

  // ----------------------------------------------------------------
  // Condition decode
  // ----------------------------------------------------------------
  // Flags are only read here, never written back
  always @* begin
    hit = 1'b0;
    case (op)
      `BSLE_OP_SKIP_IF_REG_BIT_CLEAR: hit = ~reg_val[sel_bit]; // [RQ1]
      `BSLE_OP_SKIP_IF_REG_BIT_SET:   hit = reg_val[sel_bit];  // [RQ2]
      `BSLE_OP_SKIP_IF_IO_BIT_CLEAR:  hit = ~io_val[sel_bit];  // [RQ3]
      `BSLE_OP_SKIP_IF_IO_BIT_SET:    hit = io_val[sel_bit];   // [RQ4]
      `BSLE_OP_BRANCH_FLAG_SET:       hit = flags[sel_bit];    // [RQ5]
      `BSLE_OP_BRANCH_FLAG_CLEAR:     hit = ~flags[sel_bit];   // [RQ5]
      `BSLE_OP_BRANCH_ON_EQUAL:     hit = flags[`BSLE_FLAG_Z];  // [RQ6]
      `BSLE_OP_BRANCH_ON_UNEQUAL:   hit = ~flags[`BSLE_FLAG_Z]; // [RQ6]
      `BSLE_OP_BRANCH_CARRY_SET:    hit = flags[`BSLE_FLAG_C];  // [RQ7]
      `BSLE_OP_BRANCH_CARRY_CLEAR:  hit = ~flags[`BSLE_FLAG_C]; // [RQ7]
      `BSLE_OP_BRANCH_UNSIGNED_GE:  hit = ~flags[`BSLE_FLAG_C]; // [RQ8]
      `BSLE_OP_BRANCH_UNSIGNED_LT:  hit = flags[`BSLE_FLAG_C];  // [RQ8]
      `BSLE_OP_BRANCH_NEGATIVE:     hit = flags[`BSLE_FLAG_N];  // [RQ9]
      `BSLE_OP_BRANCH_NONNEGATIVE:  hit = ~flags[`BSLE_FLAG_N]; // [RQ9]
      `BSLE_OP_BRANCH_SIGNED_GE:
        hit = ~(flags[`BSLE_FLAG_N] ^ flags[`BSLE_FLAG_V]);    // [RQ10]
      `BSLE_OP_BRANCH_SIGNED_LT:
        hit = flags[`BSLE_FLAG_N] ^ flags[`BSLE_FLAG_V];       // [RQ10]
      `BSLE_OP_BRANCH_HALFCARRY_SET:   hit = flags[`BSLE_FLAG_H];  // [RQ11]
      `BSLE_OP_BRANCH_HALFCARRY_CLEAR: hit = ~flags[`BSLE_FLAG_H]; // [RQ11]
      `BSLE_OP_BRANCH_USER_BIT_SET:    hit = flags[`BSLE_FLAG_T];  // [RQ12]
      `BSLE_OP_BRANCH_USER_BIT_CLEAR:  hit = ~flags[`BSLE_FLAG_T]; // [RQ12]
      `BSLE_OP_BRANCH_OVERFLOW_SET:    hit = flags[`BSLE_FLAG_V];  // [RQ13]
      `BSLE_OP_BRANCH_OVERFLOW_CLEAR:  hit = ~flags[`BSLE_FLAG_V]; // [RQ13]
      `BSLE_OP_BRANCH_INTERRUPTS_ON:   hit = flags[`BSLE_FLAG_I];  // [RQ14]
      `BSLE_OP_BRANCH_INTERRUPTS_OFF:  hit = ~flags[`BSLE_FLAG_I]; // [RQ14]
      default: hit = 1'b0;
    endcase
  end

endmodule // bsle_cond

// >>> logic/bsle_exec.v
// Skip, relative branch and data load execution unit
// Function
// RQ1 - Skip next when register bit clear
// RQ2 - Skip next when register bit set
// RQ3 - Skip next when I/O bit clear
// RQ4 - Skip next when I/O bit set
// RQ5 - Generic flag branch, set or clear
// RQ6 - Equal/unequal branch on zero flag
// RQ7 - Carry set/clear branches on carry flag
// RQ8 - Unsigned ge on carry clear, lt set
// RQ9 - Minus/plus branches on negative flag
// RQ10 - Signed ge/lt on N xor V
// RQ11 - Half carry branches on H flag
// RQ12 - Transfer bit branches on T flag
// RQ13 - Overflow branches on V flag
// RQ14 - Interrupt state branches on I flag
// RQ15 - Post-increment pointer load, two cycles
// RQ16 - Pre-decrement pointer load, two cycles
// RQ17 - Displacement load from Y or Z
// RQ18 - Direct memory load, two cycles
// RQ19 - Branch 1/2 cycles, skip 1/2/3
// RQ20 - Status flags never modified here
`include "bsle_defines.vh"

module bsle_exec (
  input  wire        mclk,
  input  wire        rst_b,
  input  wire        cmd_valid,
  output wire        cmd_ready,
  input  wire [4:0]  cmd_op,
  input  wire [15:0] cmd_pc,
  input  wire        cmd_next_long,
  input  wire [2:0]  cmd_bit,
  input  wire [7:0]  cmd_reg_val,
  input  wire [5:0]  cmd_io_addr,
  input  wire [6:0]  cmd_k,
  input  wire [1:0]  cmd_ptr_sel,
  input  wire [5:0]  cmd_disp,
  input  wire [4:0]  cmd_dest,
  input  wire [15:0] cmd_addr,
  input  wire [7:0]  flags,
  input  wire [15:0] ptr_x,
  input  wire [15:0] ptr_y,
  input  wire [15:0] ptr_z,
  output reg         io_re_q,
  output reg  [5:0]  io_addr_q,
  input  wire [7:0]  io_rdata,
  output reg         dm_re_q,
  output reg  [15:0] dm_addr_q,
  input  wire [7:0]  dm_rdata,
  output reg         ptr_we_q,
  output reg  [1:0]  ptr_wsel_q,
  output reg  [15:0] ptr_wdata_q,
  output reg         rf_we_q,
  output reg  [4:0]  rf_waddr_q,
  output reg  [7:0]  rf_wdata_q,
  output reg         done_q,
  output reg  [15:0] pc_next_q
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_IOEV = 2'h1;
  localparam [1:0] ST_LOAD = 2'h2;
  localparam [1:0] ST_WAIT = 2'h3;

  // Command context held while the unit is busy
  reg  [1:0]  state_q;
  reg  [4:0]  op_q;
  reg  [15:0] pc_q;
  reg         long_q;
  reg  [2:0]  bit_q;
  reg         load_q;
  reg  [1:0]  wait_q;
  // Condition result and load address helpers
  wire        hit;
  wire [4:0]  cond_op;
  wire [2:0]  cond_bit;
  reg  [15:0] ptr_sel_val;
  reg  [15:0] ld_addr;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Counter arithmetic wraps at 16 bits, as the fetch side expects
  function [15:0] pc_add;
    input [15:0] base;
    input [15:0] delta;
    begin
      pc_add = base + delta;
    end
  endfunction

  // Skip distance depends on the length of the instruction skipped
  function [15:0] skip_step;
    input long_next;
    begin
      skip_step = long_next ? `BSLE_PC_STEP_THREE : `BSLE_PC_STEP_TWO;
    end
  endfunction

  // Port skips need a read before they can be judged
  function is_io_skip;
    input [4:0] op;
    begin
      is_io_skip = (op == `BSLE_OP_SKIP_IF_IO_BIT_CLEAR) ||
                   (op == `BSLE_OP_SKIP_IF_IO_BIT_SET);
    end
  endfunction

  // Register skips are judged from the operand sent with the command
  function is_reg_skip;
    input [4:0] op;
    begin
      is_reg_skip = (op == `BSLE_OP_SKIP_IF_REG_BIT_CLEAR) ||
                    (op == `BSLE_OP_SKIP_IF_REG_BIT_SET);
    end
  endfunction

  // Load codes form one contiguous run at the top of the code map
  function is_load;
    input [4:0] op;
    begin
      is_load = (op >= `BSLE_OP_POINTER_LOAD_POST_INC) &&
                (op <= `BSLE_OP_DIRECT_MEMORY_LOAD);
    end
  endfunction

  // ----------------------------------------------------------------
  // Condition unit
  // ----------------------------------------------------------------
  // While idle the fresh command is judged; later the held one
  assign cmd_ready = (state_q == ST_IDLE);
  assign cond_op   = cmd_ready ? cmd_op : op_q;
  assign cond_bit  = cmd_ready ? cmd_bit : bit_q;

  bsle_cond u_cond (
    .op      (cond_op),
    .flags   (flags),
    .sel_bit (cond_bit),
    .reg_val (cmd_reg_val),
    .io_val  (io_rdata),
    .hit     (hit)
  );

  // ----------------------------------------------------------------
  // Load address formation
  // ----------------------------------------------------------------
  // Displacement only uses Y or Z; an X selector falls back to Y
  always @* begin
    case (cmd_ptr_sel)
      `BSLE_PTR_X: ptr_sel_val = ptr_x;
      `BSLE_PTR_Y: ptr_sel_val = ptr_y;
      default:     ptr_sel_val = ptr_z;
    endcase
    // Read address for each load form
    case (cmd_op)
      `BSLE_OP_POINTER_LOAD_PRE_DEC:
        ld_addr = ptr_sel_val - `BSLE_PC_STEP_ONE;          // [RQ16]
      `BSLE_OP_POINTER_OFFSET_LOAD:
        ld_addr = ((cmd_ptr_sel == `BSLE_PTR_Z) ? ptr_z : ptr_y) +
                  {10'h000, cmd_disp};                      // [RQ17]
      `BSLE_OP_DIRECT_MEMORY_LOAD:
        ld_addr = cmd_addr;                                 // [RQ18]
      default:
        ld_addr = ptr_sel_val;                              // [RQ15]
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // No flag write port exists, so every status bit is left as is
  // [RQ20]
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_q     <= ST_IDLE;
      op_q        <= 5'h00;
      pc_q        <= `BSLE_RST_ADDR;
      long_q      <= 1'b0;
      bit_q       <= 3'h0;
      load_q      <= 1'b0;
      wait_q      <= `BSLE_WAIT_NONE;
      io_re_q     <= 1'b0;
      io_addr_q   <= 6'h00;
      dm_re_q     <= 1'b0;
      dm_addr_q   <= `BSLE_RST_ADDR;
      ptr_we_q    <= 1'b0;
      ptr_wsel_q  <= `BSLE_PTR_X;
      ptr_wdata_q <= `BSLE_RST_ADDR;
      rf_we_q     <= 1'b0;
      rf_waddr_q  <= 5'h00;
      rf_wdata_q  <= `BSLE_RST_BYTE;
      done_q      <= 1'b0;
      pc_next_q   <= `BSLE_RST_ADDR;
    end else begin
      // Strobes last one cycle unless re-armed below
      io_re_q  <= 1'b0;
      dm_re_q  <= 1'b0;
      ptr_we_q <= 1'b0;
      rf_we_q  <= 1'b0;
      done_q   <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (cmd_valid) begin
            // Capture the command so later states need no live input
            op_q       <= cmd_op;
            pc_q       <= cmd_pc;
            long_q     <= cmd_next_long;
            bit_q      <= cmd_bit;
            rf_waddr_q <= cmd_dest;
            load_q     <= is_load(cmd_op);
            if (is_io_skip(cmd_op)) begin
              // I/O space answers while the read strobe and address stand
              io_re_q   <= 1'b1;
              io_addr_q <= cmd_io_addr;                     // [RQ3] [RQ4]
              state_q   <= ST_IOEV;
            end else if (is_load(cmd_op)) begin
              // Memory answers while the read strobe stands
              dm_re_q   <= 1'b1;
              dm_addr_q <= ld_addr;
              state_q   <= ST_LOAD;
              // Direct load is a two-word instruction
              if (cmd_op == `BSLE_OP_DIRECT_MEMORY_LOAD) begin
                pc_next_q <= pc_add(cmd_pc, `BSLE_PC_STEP_TWO); // [RQ18]
              end else begin
                pc_next_q <= pc_add(cmd_pc, `BSLE_PC_STEP_ONE);
              end
              // Write-back leaves with the read, which uses the old value
              if (cmd_op == `BSLE_OP_POINTER_LOAD_POST_INC) begin
                ptr_we_q    <= 1'b1;
                ptr_wsel_q  <= cmd_ptr_sel;
                ptr_wdata_q <= ptr_sel_val + `BSLE_PC_STEP_ONE; // [RQ15]
              end else if (cmd_op == `BSLE_OP_POINTER_LOAD_PRE_DEC) begin
                // Read and write back the same decremented address
                ptr_we_q    <= 1'b1;
                ptr_wsel_q  <= cmd_ptr_sel;
                ptr_wdata_q <= ld_addr;                      // [RQ16]
              end
            end else if (is_reg_skip(cmd_op)) begin
              state_q <= ST_WAIT;
              if (hit) begin
                pc_next_q <= pc_add(cmd_pc,
                                    skip_step(cmd_next_long)); // [RQ1] [RQ2]
                wait_q    <= cmd_next_long ? `BSLE_WAIT_TWO
                                           : `BSLE_WAIT_ONE;  // [RQ19]
              end else begin
                pc_next_q <= pc_add(cmd_pc, `BSLE_PC_STEP_ONE);
                wait_q    <= `BSLE_WAIT_NONE;                // [RQ19]
              end
            end else begin
              // Every remaining code is a relative branch
              // Offset is in signed words; the sum wraps with the counter
              state_q <= ST_WAIT;
              if (hit) begin
                pc_next_q <= pc_add(cmd_pc,
                                    {{9{cmd_k[6]}}, cmd_k} +
                                    `BSLE_PC_STEP_ONE);      // [RQ5]
                wait_q    <= `BSLE_WAIT_ONE;                 // [RQ19]
              end else begin
                pc_next_q <= pc_add(cmd_pc, `BSLE_PC_STEP_ONE);
                wait_q    <= `BSLE_WAIT_NONE;                // [RQ19]
              end
            end
          end
        end
        ST_IOEV: begin
          // Port data stands now; the held code and bit judge it
          if (hit) begin
            pc_next_q <= pc_add(pc_q, skip_step(long_q));    // [RQ3] [RQ4]
            wait_q    <= long_q ? `BSLE_WAIT_ONE
                                : `BSLE_WAIT_NONE;           // [RQ19]
            state_q   <= ST_WAIT;
          end else begin
            pc_next_q <= pc_add(pc_q, `BSLE_PC_STEP_ONE);
            done_q    <= 1'b1;                               // [RQ19]
            state_q   <= ST_IDLE;
          end
        end
        ST_LOAD: begin
          // Memory data is taken while the read strobe stands
          rf_wdata_q <= dm_rdata;                            // [RQ15]
          wait_q     <= `BSLE_WAIT_NONE;
          state_q    <= ST_WAIT;
        end
        ST_WAIT: begin
          // Burns the extra cycles that a taken branch or skip costs
          if (wait_q == `BSLE_WAIT_NONE) begin
            done_q  <= 1'b1;
            rf_we_q <= load_q;                               // [RQ18]
            state_q <= ST_IDLE;
          end else begin
            wait_q <= wait_q - `BSLE_WAIT_ONE;
          end
        end
        default: begin
          // Unused state code: recover to idle rather than hang
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // bsle_exec

// >>> tb/bsle_exec_sva.sv
// Port-level checker for the skip, branch and load execution unit
`include "bsle_defines.vh"
module bsle_exec_sva (
  input wire        mclk,
  input wire        rst_b,
  input wire        cmd_valid,
  input wire        cmd_ready,
  input wire [4:0]  cmd_op,
  input wire [15:0] cmd_pc,
  input wire        cmd_next_long,
  input wire [2:0]  cmd_bit,
  input wire [7:0]  cmd_reg_val,
  input wire [5:0]  cmd_io_addr,
  input wire [6:0]  cmd_k,
  input wire [1:0]  cmd_ptr_sel,
  input wire [15:0] cmd_addr,
  input wire [7:0]  flags,
  input wire [15:0] ptr_z,
  input wire        io_re_q,
  input wire [5:0]  io_addr_q,
  input wire        dm_re_q,
  input wire [15:0] dm_addr_q,
  input wire        ptr_we_q,
  input wire [15:0] ptr_wdata_q,
  input wire        rf_we_q,
  input wire        done_q,
  input wire [15:0] pc_next_q
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Target wraps at 16 bits, as the unit's adder does
  wire        acc  = cmd_valid && cmd_ready;
  wire        rbit = cmd_reg_val[cmd_bit];
  wire [15:0] tgt  = cmd_pc + {{9{cmd_k[6]}}, cmd_k} + 16'h0001;
  // Done after one, two or three busy cycles
  sequence done1; !done_q ##1 done_q; endsequence
  sequence done2; !done_q [*2] ##1 done_q; endsequence
  sequence done3; !done_q [*3] ##1 done_q; endsequence
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  busy_refuse_a: assert property (acc |=> !cmd_ready)
    else $error("ready high after accept");
  done_pulse_a: assert property (done_q |=> !done_q)
    else $error("done longer than one cycle");
  skip_long_a: assert property (
    acc && cmd_op == `BSLE_OP_SKIP_IF_REG_BIT_CLEAR && !rbit && cmd_next_long
    |=> done3 ##0 pc_next_q == $past(cmd_pc, 4) + 16'h0003)
    else $error("long skip wrong");
  skip_short_a: assert property (
    acc && cmd_op == `BSLE_OP_SKIP_IF_REG_BIT_SET && rbit && !cmd_next_long
    |=> done2 ##0 pc_next_q == $past(cmd_pc, 3) + 16'h0002)
    else $error("short skip wrong");
  no_skip_a: assert property (
    acc && cmd_op[4:1] == 4'h0 && rbit != cmd_op[0]
    |=> done1 ##0 pc_next_q == $past(cmd_pc, 2) + 16'h0001)
    else $error("skip without cause");
  io_read_a: assert property (
    acc && cmd_op[4:1] == 4'h1
    |=> io_re_q && io_addr_q == $past(cmd_io_addr) ##1 !io_re_q)
    else $error("io read request wrong");
  flag_taken_a: assert property (
    acc && cmd_op == `BSLE_OP_BRANCH_FLAG_SET && flags[cmd_bit]
    |=> done2 ##0 pc_next_q == $past(tgt, 3))
    else $error("flag branch target wrong");
  eq_not_a: assert property (
    acc && cmd_op == `BSLE_OP_BRANCH_ON_EQUAL && !flags[`BSLE_FLAG_Z]
    |=> done1 ##0 pc_next_q == $past(cmd_pc, 2) + 16'h0001)
    else $error("equal branch taken wrongly");
  lt_taken_a: assert property (
    acc && cmd_op == `BSLE_OP_BRANCH_SIGNED_LT
    && (flags[`BSLE_FLAG_N] ^ flags[`BSLE_FLAG_V])
    |=> done2 ##0 pc_next_q == $past(tgt, 3))
    else $error("signed less branch wrong");
  pre_dec_a: assert property (
    acc && cmd_op == `BSLE_OP_POINTER_LOAD_PRE_DEC
    && cmd_ptr_sel == `BSLE_PTR_Z |=> dm_re_q && ptr_we_q
    && dm_addr_q == $past(ptr_z) - 16'h0001 && ptr_wdata_q == dm_addr_q)
    else $error("pre-decrement address wrong");
  direct_ld_a: assert property (
    acc && cmd_op == `BSLE_OP_DIRECT_MEMORY_LOAD
    |=> dm_re_q && !ptr_we_q && dm_addr_q == $past(cmd_addr) ##0 done2
    ##0 rf_we_q && pc_next_q == $past(cmd_pc, 3) + 16'h0002)
    else $error("direct load wrong");
endmodule // bsle_exec_sva

bind bsle_exec bsle_exec_sva chk (
  .mclk, .rst_b, .cmd_valid, .cmd_ready, .cmd_op, .cmd_pc, .cmd_next_long,
  .cmd_bit, .cmd_reg_val, .cmd_io_addr, .cmd_k, .cmd_ptr_sel, .cmd_addr,
  .flags, .ptr_z, .io_re_q, .io_addr_q, .dm_re_q, .dm_addr_q, .ptr_we_q,
  .ptr_wdata_q, .rf_we_q, .done_q, .pc_next_q
);

// >>> tb/tb.sv
// Self-checking bench for the skip, branch and load execution unit
`include "bsle_defines.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk, rst_b, cmd_valid, cmd_next_long;
  logic [4:0]  cmd_op, cmd_dest;
  logic [15:0] cmd_pc, cmd_addr, ptr_x, ptr_y, ptr_z;
  logic [2:0]  cmd_bit;
  logic [7:0]  cmd_reg_val, flags;
  logic [5:0]  cmd_io_addr, cmd_disp;
  logic [6:0]  cmd_k;
  logic [1:0]  cmd_ptr_sel;
  logic [31:0] rnd, ra, rb, rc;
  wire         cmd_ready, io_re_q, dm_re_q, ptr_we_q, rf_we_q, done_q;
  wire  [1:0]  ptr_wsel_q;
  wire  [5:0]  io_addr_q;
  wire  [15:0] dm_addr_q, ptr_wdata_q, pc_next_q;
  wire  [4:0]  rf_waddr_q;
  wire  [7:0]  rf_wdata_q, io_rdata, dm_rdata;
  int          err_count, num_checks, cyc;

  bsle_exec dut (.mclk, .rst_b, .cmd_valid, .cmd_ready, .cmd_op, .cmd_pc,
    .cmd_next_long, .cmd_bit, .cmd_reg_val, .cmd_io_addr, .cmd_k,
    .cmd_ptr_sel, .cmd_disp, .cmd_dest, .cmd_addr, .flags, .ptr_x, .ptr_y,
    .ptr_z, .io_re_q, .io_addr_q, .io_rdata, .dm_re_q, .dm_addr_q,
    .dm_rdata, .ptr_we_q, .ptr_wsel_q, .ptr_wdata_q, .rf_we_q, .rf_waddr_q,
    .rf_wdata_q, .done_q, .pc_next_q);

  // ------------------------------------------------------------
  // Memory models and reference functions
  // ------------------------------------------------------------
  function automatic logic [7:0] io_val(input logic [5:0] a);
    io_val = {a[1:0], a} ^ 8'h3c;
  endfunction
  function automatic logic [7:0] dm_val(input logic [15:0] a);
    dm_val = a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Read data inverts outside the strobe, so late sampling shows up
  assign io_rdata = io_re_q ? io_val(io_addr_q) : ~io_val(io_addr_q);
  assign dm_rdata = dm_re_q ? dm_val(dm_addr_q) : ~dm_val(dm_addr_q);
  // Even codes test the sense below, odd codes its inverse
  function automatic logic hit();
    logic [7:0] io;
    logic       v;
    io = io_val(cmd_io_addr);
    case (cmd_op[4:1])
      4'h0: v = !cmd_reg_val[cmd_bit];
      4'h1: v = !io[cmd_bit];
      4'h2: v = flags[cmd_bit];
      4'h3: v = flags[`BSLE_FLAG_Z];
      4'h4: v = flags[`BSLE_FLAG_C];
      4'h5: v = !flags[`BSLE_FLAG_C];
      4'h6: v = flags[`BSLE_FLAG_N];
      4'h7: v = !(flags[`BSLE_FLAG_N] ^ flags[`BSLE_FLAG_V]);
      4'h8: v = flags[`BSLE_FLAG_H];
      4'h9: v = flags[`BSLE_FLAG_T];
      4'ha: v = flags[`BSLE_FLAG_V];
      default: v = flags[`BSLE_FLAG_I];
    endcase
    hit = cmd_op[0] ? !v : v;
  endfunction

  // ------------------------------------------------------------
  // Checks and run control
  // ------------------------------------------------------------
  task automatic check(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("Error at %0t ns: %s", $time, m);
    end
  endtask
  task automatic summarize();
    if (err_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Offer the command on the cmd_ inputs and follow it to done
  task automatic run();
    int          n, en;
    logic [15:0] ep, ea, epw, base, sa, pw;
    logic [1:0]  ps;
    logic [4:0]  o;
    logic        pwe;
    cmd_valid <= 1'b1;
    #1;
    o = cmd_op;
    base = (cmd_ptr_sel == `BSLE_PTR_X) ? ptr_x :
           (cmd_ptr_sel == `BSLE_PTR_Y) ? ptr_y : ptr_z;
    en = (o < 5'h1c && hit()) ? 2 : 1;
    ep = cmd_pc + 16'h0001;
    if (o < 5'h04 && hit() && cmd_next_long) en = 3;
    if (o < 5'h04) ep = cmd_pc + en[15:0];
    else if (o < 5'h18 && hit()) ep = ep + {{9{cmd_k[6]}}, cmd_k};
    else if (o >= 5'h18 && o < 5'h1c) en = 2;
    ea = (o == `BSLE_OP_POINTER_LOAD_PRE_DEC) ? base - 16'h0001 : base;
    epw = (o == `BSLE_OP_POINTER_LOAD_PRE_DEC) ? ea : base + 16'h0001;
    if (o == `BSLE_OP_POINTER_OFFSET_LOAD)
      ea = ((cmd_ptr_sel == `BSLE_PTR_Z) ? ptr_z : ptr_y) + cmd_disp;
    if (o == `BSLE_OP_DIRECT_MEMORY_LOAD) ea = cmd_addr;
    if (o == `BSLE_OP_DIRECT_MEMORY_LOAD) ep = cmd_pc + 16'h0002;
    do @(posedge mclk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    #1;
    n = 0;
    pwe = 1'b0;
    sa = 'x;
    while (done_q !== 1'b1 && n < 6) begin
      if (dm_re_q === 1'b1) sa = dm_addr_q;
      if (ptr_we_q === 1'b1) begin
        pwe = 1'b1;
        pw = ptr_wdata_q;
        ps = ptr_wsel_q;
      end
      @(posedge mclk);
      #1;
      n++;
    end
    check(n == en, "cycle count");
    if (o < 5'h04) check(pc_next_q === ep, "pc");
    else if (o < 5'h0c) check(pc_next_q === ep, "pc");
    else if (o < 5'h12) check(pc_next_q === ep, "pc");
    else if (o < 5'h18) check(pc_next_q === ep, "pc");
    else check(pc_next_q === ep, "pc");
    if (o >= 5'h18 && o < 5'h1c) begin
      check(sa === ea, "load address");
      check(rf_we_q && rf_waddr_q === cmd_dest, "load dest");
      check(rf_wdata_q === dm_val(ea), "load data");
    end else check(rf_we_q === 1'b0 && !pwe, "stray write");
    if (o[4:1] == 4'hc)
      check(pwe && pw === epw && ps === cmd_ptr_sel, "ptr");
    else if (o == `BSLE_OP_POINTER_OFFSET_LOAD)
      check(!pwe, "ptr kept");
  endtask

  // Clock and hang guard
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      err_count++;
      summarize();
    end
  end

  // First pass walks every code with wrapping corners, then random
  initial begin
    {cmd_valid, cmd_next_long, cmd_op, cmd_dest, cmd_pc, cmd_addr} = '0;
    {ptr_x, ptr_y, ptr_z, cmd_bit, cmd_reg_val, flags} = '0;
    {cmd_io_addr, cmd_disp, cmd_k, cmd_ptr_sel} = '0;
    {err_count, num_checks, cyc} = '0;
    rst_b = 1'b0;
    rnd = 32'd88566;
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    for (int i = 0; i < 320; i++) begin
      repeat (32) rnd = lfsr(rnd);
      ra = rnd;
      repeat (32) rnd = lfsr(rnd);
      rb = rnd;
      repeat (32) rnd = lfsr(rnd);
      rc = rnd;
      @(posedge mclk);
      cmd_op        <= (i < 32) ? i[4:0] : ra[4:0];
      cmd_next_long <= ra[5];
      cmd_bit       <= ra[8:6];
      cmd_k         <= (i < 32) ? {i[0], {6{~i[0]}}} : ra[15:9];
      cmd_pc        <= (i < 32) ? {16{i[1]}} : ra[31:16];
      cmd_reg_val   <= rb[7:0];
      flags         <= rb[15:8];
      cmd_io_addr   <= rb[21:16];
      cmd_disp      <= (i < 32) ? 6'h3f : rb[27:22];
      cmd_ptr_sel   <= 2'((i < 32 ? i : int'(rb[29:28])) % 3);
      cmd_dest      <= rc[4:0];
      cmd_addr      <= rc[31:16];
      ptr_x         <= (i < 32) ? 16'h0000 : rc[15:0];
      ptr_y         <= (i < 32) ? 16'hffff : rb[15:0] ^ rc[31:16];
      ptr_z         <= (i < 32) ? {16{i[2]}} : ra[15:0] ^ rc[15:0];
      run();
    end
    summarize();
  end
endmodule // tb
